// ### rtl/agp_pkg.sv
package agp_pkg;

    // ==========================================
    // Register map
    localparam logic [7:0]  CFG_ADDR     = 8'h81;
    localparam logic [15:0] CFG_RESET    = 16'h8000;
    localparam logic [15:0] CFG_WR_MASK  = 16'h7fff;
    localparam logic [15:0] CFG_RSV_MASK = 16'h8000;
    localparam logic [15:0] SPARE_MASK   = 16'h700c;
    localparam logic [15:0] RD_UNMAPPED  = 16'h0000;

    // ==========================================
    // Field positions
    localparam int RSV_BIT      = 15;
    localparam int FMT_ONE      = 11;
    localparam int FMT_ZERO     = 10;
    localparam int DIR_ONE      = 9;
    localparam int DIR_ZERO     = 8;
    localparam int TB_ONE_MSB   = 7;
    localparam int TB_ONE_LSB   = 6;
    localparam int TB_ZERO_MSB  = 5;
    localparam int TB_ZERO_LSB  = 4;
    localparam int DAT_ONE      = 1;
    localparam int DAT_ZERO     = 0;

    // ==========================================
    // Time base in master-clock periods
    localparam int TB_W = 11;
    localparam logic [TB_W-1:0] TB_PERIOD_16   = 11'h010;
    localparam logic [TB_W-1:0] TB_PERIOD_64   = 11'h040;
    localparam logic [TB_W-1:0] TB_PERIOD_256  = 11'h100;
    localparam logic [TB_W-1:0] TB_PERIOD_1024 = 11'h400;
    localparam logic [TB_W-1:0] TB_ONE         = 11'h001;
    localparam int DUR_W = 8;

    typedef enum logic [1:0] {
        AGP_DEC_OFF = 2'b01,
        AGP_DEC_RUN = 2'b10
    } agp_dec_state_type;

    function automatic logic [TB_W-1:0] agp_tb_period(input logic [1:0] sel);
        case (sel)
            2'h0:    agp_tb_period = TB_PERIOD_16;
            2'h1:    agp_tb_period = TB_PERIOD_64;
            2'h2:    agp_tb_period = TB_PERIOD_256;
            default: agp_tb_period = TB_PERIOD_1024;
        endcase
    endfunction : agp_tb_period

endpackage : agp_pkg

// ### rtl/agp_pwm_decoder.sv
`timescale 1ns/1ns
module agp_pwm_decoder #(
    parameter int DUR_W = agp_pkg::DUR_W
) (
    input  wire logic       core_clk,
    input  wire logic       rstN,
    input  wire logic       enable,
    input  wire logic       pinIn,
    input  wire logic [1:0] tbSel,
    output logic            level
);

    typedef struct packed {
        agp_pkg::agp_dec_state_type   state;
        logic [agp_pkg::TB_W-1:0]     divCnt;
        logic [DUR_W-1:0]             highCnt;
        logic [DUR_W-1:0]             lowCnt;
        logic                         prevPin;
        logic                         level;
    } agp_dec_type;

    agp_dec_type s_r;
    agp_dec_type s_nxt;
    logic [agp_pkg::TB_W-1:0] period;
    logic                     tick;

    assign period = agp_pkg::agp_tb_period(tbSel);
    // A shortened time base must not leave the divider stranded above it
    assign tick   = (s_r.divCnt >= period - agp_pkg::TB_ONE);
    assign level  = s_r.level;

    // ==========================================
    // Duration measurement
    always_comb begin
        logic [DUR_W-1:0] hi;
        logic [DUR_W-1:0] lo;
        hi = s_r.highCnt;
        lo = s_r.lowCnt;
        s_nxt = s_r;
        case (s_r.state)
            agp_pkg::AGP_DEC_OFF: begin
                s_nxt.divCnt  = '0;
                s_nxt.highCnt = '0;
                s_nxt.lowCnt  = '0;
                s_nxt.prevPin = pinIn;
                if (enable) begin
                    s_nxt.state = agp_pkg::AGP_DEC_RUN;
                end
            end
            agp_pkg::AGP_DEC_RUN: begin
                if (!enable) begin
                    s_nxt.state = agp_pkg::AGP_DEC_OFF;
                end else begin
                    s_nxt.divCnt  = tick ? '0
                        : agp_pkg::TB_W'(s_r.divCnt + agp_pkg::TB_ONE);
                    s_nxt.prevPin = pinIn;
                    // high must beat low, a tie reads low
                    // Saturation ends a period so a static pin still resolves
                    if ((pinIn && !s_r.prevPin) || (&hi) || (&lo)) begin
                        s_nxt.level = (hi > lo);
                        hi = '0;
                        lo = '0;
                    end
                    if (tick) begin
                        if (pinIn) begin
                            hi = DUR_W'(hi + 1'b1);
                        end else begin
                            lo = DUR_W'(lo + 1'b1);
                        end
                    end
                    s_nxt.highCnt = hi;
                    s_nxt.lowCnt  = lo;
                end
            end
            default: begin
                s_nxt.state = agp_pkg::AGP_DEC_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            s_r <= '{state: agp_pkg::AGP_DEC_OFF, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================
    // Checks
    logic [agp_pkg::TB_W-1:0] gap_r;
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            gap_r <= '0;
        end else begin
            gap_r <= (tick || !enable) ? '0
                : agp_pkg::TB_W'(gap_r + agp_pkg::TB_ONE);
        end
    end

    tb_span_a: assert property (@(posedge core_clk) disable iff (!rstN)
        s_r.state == agp_pkg::AGP_DEC_RUN && $stable(tbSel)
        |-> gap_r <= period)
        else $error("time base counter ran past its period");

    decide_a: assert property (@(posedge core_clk) disable iff (!rstN)
        s_r.state == agp_pkg::AGP_DEC_RUN && enable && pinIn && !s_r.prevPin
        |=> level == ($past(s_r.highCnt) > $past(s_r.lowCnt)))
        else $error("decoded level does not follow high against low");

endmodule : agp_pwm_decoder

// ### rtl/agp_pin_pair.sv
`timescale 1ns/1ns
module agp_pin_pair #(
    parameter int DUR_W = agp_pkg::DUR_W
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWrData,
    output logic      [15:0] regRdData,
    output logic             regRdValid,
    input  wire logic        pinOneIn,
    output logic             pinOneOut,
    output logic             pinOneOe,
    input  wire logic        pinZeroIn,
    output logic             pinZeroOut,
    output logic             pinZeroOe,
    output logic             pinOneLevel,
    output logic             pinZeroLevel
);

    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] rdData;
        logic        rdValid;
        logic [1:0]  pinOut;
        logic [1:0]  pinOe;
        logic [1:0]  level;
    } agp_state_type;

    agp_state_type s_r;
    agp_state_type s_nxt;
    logic [1:0]    rstSync_r;
    logic          rstN;
    logic          addrHit;
    logic [1:0]    pinIn;
    logic [1:0]    dirBit;
    logic [1:0]    fmtBit;
    logic [1:0]    datBit;
    logic [1:0]    tbSel [2];
    logic [1:0]    decLevel;
    logic [1:0]    decEn;

    // ==========================================
    // Reset release
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_r <= 2'h0;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rstN = rstSync_r[1];

    // ==========================================
    // Field decode
    assign addrHit   = (regAddr == agp_pkg::CFG_ADDR);
    assign pinIn     = {pinOneIn, pinZeroIn};
    assign dirBit    = {s_r.cfg[agp_pkg::DIR_ONE], s_r.cfg[agp_pkg::DIR_ZERO]};
    assign fmtBit    = {s_r.cfg[agp_pkg::FMT_ONE], s_r.cfg[agp_pkg::FMT_ZERO]};
    assign datBit    = {s_r.cfg[agp_pkg::DAT_ONE], s_r.cfg[agp_pkg::DAT_ZERO]};
    assign tbSel[1]  = s_r.cfg[agp_pkg::TB_ONE_MSB:agp_pkg::TB_ONE_LSB];
    assign tbSel[0]  = s_r.cfg[agp_pkg::TB_ZERO_MSB:agp_pkg::TB_ZERO_LSB];

    // ==========================================
    // Per-pin decoders
    // Decoder only runs while needed, so each switch into PWM input restarts its counters clean; the decoded level keeps its old value
    for (genvar i = 0; i < 2; i++) begin : g_pin
        assign decEn[i] = !dirBit[i] && fmtBit[i];
        agp_pwm_decoder #(
            .DUR_W (DUR_W)
        ) u_dec (
            .core_clk (core_clk),
            .rstN     (rstN),
            .enable   (decEn[i]),
            .pinIn    (pinIn[i]),
            .tbSel    (tbSel[i]),
            .level    (decLevel[i])
        );
    end

    // ==========================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        if (regWrEn && addrHit) begin
            s_nxt.cfg = (regWrData & agp_pkg::CFG_WR_MASK)
                      | agp_pkg::CFG_RSV_MASK;
        end
        // A read in the write cycle returns the old value
        s_nxt.rdValid = regRdEn;
        if (regRdEn) begin
            s_nxt.rdData = addrHit ? s_r.cfg : agp_pkg::RD_UNMAPPED;
        end
        for (int i = 0; i < 2; i++) begin
            s_nxt.pinOe[i]  = dirBit[i];
            s_nxt.pinOut[i] = dirBit[i] && datBit[i];
            if (dirBit[i]) begin
                s_nxt.level[i] = datBit[i];
            end else if (fmtBit[i]) begin
                s_nxt.level[i] = decLevel[i];
            end else begin
                s_nxt.level[i] = pinIn[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            s_r <= '{cfg: agp_pkg::CFG_RESET, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign regRdData    = s_r.rdData;
    assign regRdValid   = s_r.rdValid;
    assign pinOneOut    = s_r.pinOut[1];
    assign pinOneOe     = s_r.pinOe[1];
    assign pinZeroOut   = s_r.pinOut[0];
    assign pinZeroOe    = s_r.pinOe[0];
    assign pinOneLevel  = s_r.level[1];
    assign pinZeroLevel = s_r.level[0];

    // ==========================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstN);

    spare_store_a: assert property (
        regWrEn && addrHit
        |=> ((s_r.cfg ^ $past(regWrData)) & agp_pkg::SPARE_MASK) == 16'h0000)
        else $error("spare bits did not store the written value");

    wr_refused_a: assert property (
        !(regWrEn && addrHit) |=> $stable(s_r.cfg))
        else $error("register changed without a mapped write");

    rd_data_a: assert property (
        regRdEn && addrHit |=> regRdData == $past(s_r.cfg))
        else $error("read did not return the stored register");

    dir_one_a: assert property (
        pinOneOe == $past(dirBit[1]))
        else $error("pin one output enable does not follow direction");

    in_one_a: assert property (
        !dirBit[1] |=> !pinOneOe && !pinOneOut)
        else $error("pin one drives while set as input");

    dir_zero_a: assert property (
        !dirBit[0] |=> !pinZeroOe && !pinZeroOut)
        else $error("pin zero drives while set as input");

    out_zero_a: assert property (
        dirBit[0] |=> pinZeroOe)
        else $error("pin zero not driven while set as output");

    fmt_one_a: assert property (
        !dirBit[1] && !fmtBit[1] |=> pinOneLevel == $past(pinOneIn))
        else $error("pin one static level not taken from pin");

    pwm_one_a: assert property (
        !dirBit[1] && fmtBit[1] |=> pinOneLevel == $past(decLevel[1]))
        else $error("pin one level not taken from decoder");

    fmt_zero_a: assert property (
        !dirBit[0] && fmtBit[0] |=> pinZeroLevel == $past(decLevel[0]))
        else $error("pin zero level not taken from decoder");

    static_zero_a: assert property (
        !dirBit[0] && !fmtBit[0] |=> pinZeroLevel == $past(pinZeroIn))
        else $error("pin zero static level not taken from pin");

    out_static_a: assert property (
        dirBit[1] && fmtBit[1] |=> pinOneOe && pinOneOut == $past(datBit[1]))
        else $error("pin one output not static with format set");

    static_zero_out_a: assert property (
        dirBit[0] && fmtBit[0]
        |=> pinZeroOe && pinZeroOut == $past(datBit[0]))
        else $error("pin zero output not static with format set");

    tb_one_a: assert property (
        $changed(tbSel[1]) |-> $past(regWrEn) && $past(addrHit))
        else $error("pin one time base changed without a write");

    tb_one_pick_a: assert property (
        regWrEn && addrHit
        |=> tbSel[1] == $past(regWrData[agp_pkg::TB_ONE_MSB:agp_pkg::TB_ONE_LSB]))
        else $error("pin one time base not taken from its field");

    tb_zero_a: assert property (
        $changed(tbSel[0]) |-> $past(regWrEn) && $past(addrHit))
        else $error("pin zero time base changed without a write");

    tb_zero_pick_a: assert property (
        regWrEn && addrHit
        |=> tbSel[0] == $past(regWrData[agp_pkg::TB_ZERO_MSB:agp_pkg::TB_ZERO_LSB]))
        else $error("pin zero time base not taken from its field");

    data_one_a: assert property (
        dirBit[1] |=> pinOneOe && pinOneOut == $past(datBit[1]))
        else $error("pin one does not drive its data bit");

    level_one_a: assert property (
        dirBit[1] |=> pinOneLevel == $past(datBit[1]))
        else $error("pin one level does not show its data bit");

    data_zero_a: assert property (
        dirBit[0] |=> pinZeroOe && pinZeroOut == $past(datBit[0]))
        else $error("pin zero does not drive its data bit");

    level_zero_a: assert property (
        dirBit[0] |=> pinZeroLevel == $past(datBit[0]))
        else $error("pin zero level does not show its data bit");

    rsv_bit_a: assert property (
        regRdEn && addrHit |=> regRdValid && regRdData[agp_pkg::RSV_BIT])
        else $error("reserved bit did not read as one");

    rsv_write_a: assert property (
        regWrEn && addrHit && !regWrData[agp_pkg::RSV_BIT]
        |=> s_r.cfg[agp_pkg::RSV_BIT])
        else $error("reserved bit cleared by a write");

    unmapped_a: assert property (
        regRdEn && !addrHit |=> regRdValid && regRdData == 16'h0000)
        else $error("unmapped read did not return zero");

    rd_valid_a: assert property (
        regRdEn |=> regRdValid)
        else $error("read strobe not answered by valid");

    rd_pulse_a: assert property (
        !regRdEn |=> !regRdValid)
        else $error("read valid without a read strobe");

    rd_hold_a: assert property (
        !regRdEn |=> $stable(regRdData))
        else $error("read data changed without a read strobe");

    // ==========================================
    // Scenarios
    pwm_in_c: cover property (
        decEn[1] ##1 decEn[1] [*8] ##1 pinOneLevel);

    both_out_c: cover property (
        pinOneOe && pinZeroOe && pinOneOut && !pinZeroOut);

    wr_rd_c: cover property (
        regWrEn && addrHit ##1 regRdEn && addrHit ##1 regRdValid);

    static_in_c: cover property (
        !pinZeroOe ##1 pinZeroLevel);

    pwm_zero_c: cover property (
        decEn[0] ##1 decEn[0] [*8] ##1 $rose(pinZeroLevel));

endmodule : agp_pin_pair

// ### dv/agp_pin_partner.sv
`timescale 1ns/1ns
module agp_pin_partner (
    input  wire logic        core_clk,
    input  wire logic        pinOut,
    input  wire logic        pinOe,
    input  wire logic        pwmOn,
    input  wire logic        staticLvl,
    input  wire logic [15:0] highClks,
    input  wire logic [15:0] periodClks,
    output logic             pinIn
);
    // ==========================================
    // External source
    logic [15:0] phaseCnt = 16'h0000;
    logic        srcLvl;

    // Free-running period; a shortened period wraps at once
    always @(posedge core_clk) begin
        if (phaseCnt + 16'h0001 >= periodClks) begin
            phaseCnt <= 16'h0000;
        end else begin
            phaseCnt <= phaseCnt + 16'h0001;
        end
    end

    assign srcLvl = pwmOn ? (phaseCnt < highClks) : staticLvl;

    // Device drive overrides the source while its enable is high
    assign pinIn = pinOe ? pinOut : srcLvl;
endmodule : agp_pin_partner

// ### dv/testbench.sv
`timescale 1ns/1ns
module testbench;
    // ==========================================
    // Signals
    localparam int LIMIT = 90000;
    logic        core_clk   = 1'b0;
    logic        resetN     = 1'b0;
    logic        regWrEn    = 1'b0;
    logic        regRdEn    = 1'b0;
    logic [7:0]  regAddr    = 8'h00;
    logic [15:0] regWrData  = 16'h0000;
    logic [15:0] regRdData;
    logic        regRdValid;
    wire  [1:0]  pinIn, pinOut, pinOe, pinLvl;
    logic [1:0]  pwmOn      = 2'b00;
    logic [1:0]  staticLvl  = 2'b00;
    logic [15:0] highClks [2] = '{16'h0001, 16'h0001};
    logic [15:0] periodClks [2] = '{16'h0002, 16'h0002};
    logic [15:0] cfgModel   = agp_pkg::CFG_RESET;
    int          fails      = 0;
    int          checksDone = 0;
    int          cycles     = 0;

    always #50 core_clk = ~core_clk;

    agp_pin_pair i_dut (
        .core_clk(core_clk), .reset_n(resetN), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .pinOneIn(pinIn[1]), .pinOneOut(pinOut[1]), .pinOneOe(pinOe[1]),
        .pinZeroIn(pinIn[0]), .pinZeroOut(pinOut[0]),
        .pinZeroOe(pinOe[0]), .pinOneLevel(pinLvl[1]),
        .pinZeroLevel(pinLvl[0]));

    for (genvar g = 0; g < 2; g++) begin : g_far
        agp_pin_partner i_far (
            .core_clk(core_clk), .pinOut(pinOut[g]), .pinOe(pinOe[g]),
            .pwmOn(pwmOn[g]), .staticLvl(staticLvl[g]),
            .highClks(highClks[g]), .periodClks(periodClks[g]),
            .pinIn(pinIn[g]));
    end

    // ==========================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic test_done;
        $display("checks %0d mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] s);
        checksDone++;
        if (s !== e) begin
            $display("unexpected %s: expected %h seen %h", nm, e, s);
            fails++;
        end
    endtask : chk

    // Bit 15 of the model is pinned high whatever is written
    task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrEn <= 1'b0;
        if (a === agp_pkg::CFG_ADDR) begin
            cfgModel = (d & agp_pkg::CFG_WR_MASK) | agp_pkg::CFG_RSV_MASK;
        end
    endtask : regWrite

    task automatic regRead(input logic [7:0] a, input logic [15:0] e);
        @(posedge core_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        @(negedge core_clk);
        chk("regRdValid", 16'h0001, 16'(regRdValid));
        chk("regRdData", e, regRdData);
    endtask : regRead

    // Output pins drive the data bit; inputs leave the pin undriven
    task automatic pinCheck(input logic [1:0] inLvl);
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        for (int p = 0; p < 2; p++) begin
            chk("pinOe", 16'(cfgModel[8 + p]), 16'(pinOe[p]));
            chk("pinOut", 16'(cfgModel[8 + p] & cfgModel[p]), 16'(pinOut[p]));
            chk("pinLevel", 16'(cfgModel[8 + p] ? cfgModel[p] : inLvl[p]),
                16'(pinLvl[p]));
        end
    endtask : pinCheck

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            test_done();
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        logic [31:0] rnd;
        logic [15:0] wv;
        int          tb1;
        int          tb0;
        int          mx;
        rnd = 32'hb2a09491;
        repeat (10) @(posedge core_clk);
        resetN <= 1'b1;
        repeat (4) @(posedge core_clk);
        regRead(agp_pkg::CFG_ADDR, agp_pkg::CFG_RESET);
        regRead(8'h80, agp_pkg::RD_UNMAPPED);
        pinCheck(2'b00);
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            rnd = lfsr_next(rnd);
            wv = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : rnd[15:0];
            regWrite(agp_pkg::CFG_ADDR, wv);
            regRead(agp_pkg::CFG_ADDR, cfgModel);
        end
        regWrite(8'h82, 16'h5a5a);
        regRead(agp_pkg::CFG_ADDR, cfgModel);
        $display("test register done");
        for (int d = 0; d < 4; d++) begin
            staticLvl <= ~2'(d);
            regWrite(agp_pkg::CFG_ADDR, 16'h0f00 | 16'(d));
            pinCheck(2'b00);
        end
        $display("test output done");
        for (int s = 0; s < 4; s++) begin
            staticLvl <= 2'(s);
            regWrite(agp_pkg::CFG_ADDR, 16'h0003 | 16'(s << 2));
            pinCheck(2'(s));
        end
        $display("test static input done");
        pwmOn <= 2'b11;
        for (int k = 0; k < 4; k++) begin
            tb1 = 16 << (2 * k);
            tb0 = 16 << (2 * (3 - k));
            mx = (tb1 > tb0) ? tb1 : tb0;
            periodClks[1] <= 16'(6 * tb1);
            periodClks[0] <= 16'(6 * tb0);
            regWrite(agp_pkg::CFG_ADDR,
                     16'h0c03 | 16'(k << 6) | 16'((3 - k) << 4));
            for (int p = 1; p >= 0; p--) begin
                highClks[1] <= 16'((p != 0) ? 5 * tb1 : tb1);
                highClks[0] <= 16'((p != 0) ? 5 * tb0 : tb0);
                repeat (12 * mx) @(posedge core_clk);
                pinCheck({1'(p), 1'(p)});
            end
        end
        $display("test pwm input done");
        test_done();
    end
endmodule : testbench
